// file: include/shutdown_pkg.sv
package shutdown_pkg;

    // Byte offsets of the registers on the AXI4-Lite bus.
    localparam logic [3:0] ADDR_AS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RESTART = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

    // Field positions inside the auto-shutdown control register.
    localparam int FLAG_BIT = 7;
    localparam int SRC_MSB = 6;
    localparam int SRC_LSB = 4;
    localparam int AC_MSB = 3;
    localparam int AC_LSB = 2;
    localparam int BD_MSB = 1;
    localparam int BD_LSB = 0;

    // Reset values.
    localparam logic [7:0] AS_CONTROL_RESET = 8'h00;
    localparam logic [0:0] RESTART_RESET = 1'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Interrupt status bit positions.
    localparam int IRQ_ENTER = 0;
    localparam int IRQ_LEAVE = 1;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : shutdown_pkg

// file: src/pwm_auto_shutdown.sv
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
module pwm_auto_shutdown
    import shutdown_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    // AXI4-Lite slave.
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Fault sources, all from outside the clock domain.
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic fault_pin_n,
    input wire logic [1:0] comparator_sync_enable,
    input wire logic timer_one_tick,
    // PWM waveforms from the generator, and pin drive.
    input wire logic [3:0] pwm_in,
    output logic [3:0] pwm_out,
    output logic [3:0] pwm_oe,
    output logic shutdown_active,
    output logic irq
);
    // Synchronised copies: cmp1, cmp2, pin, tick.
    logic [3:0] sync_in;
    logic cmp1_s, cmp2_s, pin_s, tick_s;
    // Comparator values held until the timer tick.
    logic cmp1_h, cmp2_h, next_cmp1_h, next_cmp2_h;
    logic [7:0] as_control, next_as_control;
    logic auto_restart_enable, next_auto_restart_enable;
    logic [1:0] irq_status, next_irq_status, irq_mask, next_irq_mask;
    logic fault, c1_eff, c2_eff, do_write, flag, next_flag;
    logic [2:0] shutdown_source_select;
    logic [1:0] ac_pin_shutdown_state, bd_pin_shutdown_state;
    // Bus handshake state.
    logic aw_taken, w_taken, next_aw_taken, next_w_taken;
    logic [3:0] aw_addr, next_aw_addr, w_strb, next_w_strb;
    logic [31:0] w_data, next_w_data, next_rdata;
    logic next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [3:0] next_pwm_out, next_pwm_oe;

    // The comparator, fault pin and tick inputs pass two flip-flops before use.
    sync_two_ff #(.WIDTH(4)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in({timer_one_tick, fault_pin_n, comparator_two,
                   comparator_one}),
        .sync_out(sync_in)
    );

    // Name the synchronised levels; synced comparators update on the tick.
    always_comb begin
        cmp1_s = sync_in[0];
        cmp2_s = sync_in[1];
        pin_s = sync_in[2];
        tick_s = sync_in[3];
        next_cmp1_h = tick_s ? cmp1_s : cmp1_h;
        next_cmp2_h = tick_s ? cmp2_s : cmp2_h;
        c1_eff = comparator_sync_enable[0] ? cmp1_h : cmp1_s;
        c2_eff = comparator_sync_enable[1] ? cmp2_h : cmp2_s;
    end

    // Decode the fault selected by the source field.
    always_comb begin
        shutdown_source_select = as_control[SRC_MSB:SRC_LSB];
        // A write goes ahead once address and data are both held and no response is pending.
        do_write = aw_taken && w_taken && !s_axi_bvalid;
        case (shutdown_source_select)
            3'h0: fault = 1'b0;
            3'h1: fault = !c1_eff;
            3'h2: fault = !c2_eff;
            3'h3: fault = !c1_eff || !c2_eff;
            3'h4: fault = !pin_s;
            3'h5: fault = !pin_s || !c1_eff;
            3'h6: fault = !pin_s || !c2_eff;
            3'h7: fault = !pin_s || !c1_eff || !c2_eff;
            default: fault = 1'b0;
        endcase
    end

    // Register file, shutdown flag and interrupt status.
    always_comb begin
        next_as_control = as_control;
        next_auto_restart_enable = auto_restart_enable;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_flag = flag;
        if (do_write && w_strb[0]) begin
            case (aw_addr)
                ADDR_AS_CONTROL: begin
                    next_as_control = w_data[7:0];
                    // Writing one forces shutdown; zero resumes.
                    next_flag = w_data[FLAG_BIT];
                end
                ADDR_RESTART: next_auto_restart_enable = w_data[0];
                ADDR_IRQ_STATUS: next_irq_status = irq_status & ~w_data[1:0];
                ADDR_IRQ_MASK: next_irq_mask = w_data[1:0];
                default: begin
                end
            endcase
        end
        // Hardware set wins over a software clear.
        if (fault) begin
            next_flag = 1'b1;
        end else if (auto_restart_enable && flag) begin
            next_flag = 1'b0;
        end
        if (next_flag && !flag) begin
            next_irq_status[IRQ_ENTER] = 1'b1;
        end
        if (!next_flag && flag) begin
            next_irq_status[IRQ_LEAVE] = 1'b1;
        end
        next_as_control[FLAG_BIT] = next_flag;
    end

    // Output stage: pass PWM or apply programmed safe states.
    // States come from the value being loaded, so pins track the register.
    always_comb begin
        ac_pin_shutdown_state = next_as_control[AC_MSB:AC_LSB];
        bd_pin_shutdown_state = next_as_control[BD_MSB:BD_LSB];
        next_pwm_out = pwm_in;
        next_pwm_oe = 4'hf;
        if (next_flag) begin
            // Bits 0 and 2 are A and C.
            next_pwm_out[0] = ac_pin_shutdown_state[0];
            next_pwm_out[2] = ac_pin_shutdown_state[0];
            next_pwm_oe[0] = !ac_pin_shutdown_state[1];
            next_pwm_oe[2] = !ac_pin_shutdown_state[1];
            // Bits 1 and 3 are B and D.
            next_pwm_out[1] = bd_pin_shutdown_state[0];
            next_pwm_out[3] = bd_pin_shutdown_state[0];
            next_pwm_oe[1] = !bd_pin_shutdown_state[1];
            next_pwm_oe[3] = !bd_pin_shutdown_state[1];
        end
    end

    // Bus channel handshakes and read data.
    always_comb begin
        next_aw_taken = aw_taken;
        next_w_taken = w_taken;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_taken = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_taken = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_taken = 1'b0;
            next_w_taken = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            case (s_axi_araddr)
                ADDR_AS_CONTROL: next_rdata[7:0] = as_control;
                ADDR_RESTART: next_rdata[0] = auto_restart_enable;
                ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
                ADDR_IRQ_MASK: next_rdata[1:0] = irq_mask;
                default: next_rresp = RESP_SLVERR;
            endcase
        end
    end

    // Register everything.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp1_h <= 1'b1;
            cmp2_h <= 1'b1;
            as_control <= AS_CONTROL_RESET;
            flag <= 1'b0;
            auto_restart_enable <= RESTART_RESET;
            irq_status <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            aw_taken <= 1'b0;
            w_taken <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0;
            pwm_out <= 4'h0;
            pwm_oe <= 4'h0;
            shutdown_active <= 1'b0;
            irq <= 1'b0;
        end else begin
            cmp1_h <= next_cmp1_h;
            cmp2_h <= next_cmp2_h;
            as_control <= next_as_control;
            flag <= next_flag;
            auto_restart_enable <= next_auto_restart_enable;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            aw_taken <= next_aw_taken;
            w_taken <= next_w_taken;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_taken && !s_axi_awready;
            s_axi_wready <= !next_w_taken && !s_axi_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            pwm_out <= next_pwm_out;
            pwm_oe <= next_pwm_oe;
            shutdown_active <= next_flag;
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // Checks.
    a_disabled_no_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (!(|shutdown_source_select) && !flag && !do_write) |=> !flag)
        else $error("Flag set with source disabled.");
    a_cmp_one_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (shutdown_source_select == 3'h1 && !c1_eff) |=> flag)
        else $error("Comparator one low did not set flag.");
    a_pin_fault: assert property (@(posedge mclk) disable iff (!rst_n)
        (shutdown_source_select == 3'h4 && !pin_s) |=> flag)
        else $error("Fault pin low did not set flag.");
    a_pin_or_cmp: assert property (@(posedge mclk) disable iff (!rst_n)
        (shutdown_source_select == 3'h7 && !c2_eff) |=> flag)
        else $error("Combined source did not set flag.");
    a_ac_state: assert property (@(posedge mclk) disable iff (!rst_n)
        flag |-> (pwm_oe[0] == !as_control[AC_MSB]))
        else $error("A/C enable wrong in shutdown.");
    a_bd_state: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag && !as_control[BD_MSB]) |-> pwm_out[3] == as_control[BD_LSB])
        else $error("D level wrong in shutdown.");
    a_sync_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (comparator_sync_enable[0] && !tick_s) |=> $stable(cmp1_h))
        else $error("Held comparator changed without tick.");
    a_flag_output: assert property (@(posedge mclk) disable iff (!rst_n)
        shutdown_active == flag)
        else $error("Shutdown output disagrees with flag.");
    a_auto_restart: assert property (@(posedge mclk) disable iff (!rst_n)
        (flag && auto_restart_enable && !fault && !do_write) |=> !flag)
        else $error("Auto restart did not clear flag.");
    c_enter: cover property (@(posedge mclk) disable iff (!rst_n) $rose(flag));
    c_restart: cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(flag) && auto_restart_enable);
    c_tristate: cover property (@(posedge mclk) disable iff (!rst_n)
        flag && pwm_oe == 4'h0);
endmodule : pwm_auto_shutdown

// file: src/sync_two_ff.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a group of level inputs.
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First stage; read by the second stage only.
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // Next values simply shift the chain along.
    always_comb begin
        next_meta = async_in;
        next_sync_out = meta;
    end

    // The fault inputs idle high, so reset loads ones to avoid a false fault.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '1;
            sync_out <= '1;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule : sync_two_ff

// file: testbench/fault_source_model.sv
`timescale 1ns/100ps
// Stands in for the two comparators, the fault pin and the timer tick.
module fault_source_model (
    input wire logic mclk,
    input wire logic [2:0] fault,
    input wire logic tick_run,
    output logic comparator_one,
    output logic comparator_two,
    output logic fault_pin_n,
    output logic timer_one_tick = 1'b0
);
    logic [1:0] phase = 2'h0; // Position inside the tick period.
    // A held fault bit pulls its line low; low means fault.
    assign comparator_one = ~fault[0];
    assign comparator_two = ~fault[1];
    assign fault_pin_n = ~fault[2];
    // The tick is high two cycles in four, and stands low when stopped.
    always_ff @(posedge mclk) begin
        phase <= phase + 2'h1;
        timer_one_tick <= tick_run & phase[1];
    end
endmodule : fault_source_model

// file: testbench/pwm_auto_shutdown_tb.sv
`timescale 1ns/100ps
module pwm_auto_shutdown_tb
    import shutdown_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, pwm_in = 4'h5;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, tick_run = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] fault = 3'h0; // Faults held by the far side.
    logic [1:0] sync_en = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, c1, c2, pin_n, tick;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] pwm_out, pwm_oe;
    logic flag, irq;
    int n_mismatch = 0;
    int n_checks = 0;

    // Free-running clock of 4 ns.
    always #2 mclk = ~mclk;

    fault_source_model u_src (.mclk(mclk), .fault(fault),
        .tick_run(tick_run), .comparator_one(c1), .comparator_two(c2),
        .fault_pin_n(pin_n), .timer_one_tick(tick));

    pwm_auto_shutdown u_dut (.mclk(mclk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comparator_one(c1), .comparator_two(c2), .fault_pin_n(pin_n),
        .comparator_sync_enable(sync_en), .timer_one_tick(tick),
        .pwm_in(pwm_in), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .shutdown_active(flag), .irq(irq));

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Compares one value with case equality and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic go(input int n);
        repeat (n) @(posedge mclk);
    endtask : go

    // One write; each channel is released at its own handshake edge.
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int i;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (i == 64) begin
            n_mismatch++;
            end_of_test();
        end
        chk("bresp", 32'(er), 32'(bresp));
    endtask : wr

    // One read; data and response are taken at the rvalid edge.
    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int i;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (i == 64) begin
            n_mismatch++;
            end_of_test();
        end
        chk("rdata", ed, rdata);
        chk("rresp", 32'(er), 32'(rresp));
    endtask : rd

    // Packs flag, source code and the two pin-state fields.
    function automatic logic [31:0] ctl(input logic f, input logic [2:0] s,
                                        input logic [3:0] st);
        return {24'h0, f, s, st};
    endfunction : ctl

    // Reset values, and a misaligned read that must be refused.
    task automatic t_reset();
        chk("oe", 32'hf, 32'(pwm_oe));
        rd(ADDR_AS_CONTROL, 32'h0, RESP_OKAY);
        rd(ADDR_RESTART, 32'h0, RESP_OKAY);
        rd(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        rd(4'h2, 32'h0, RESP_SLVERR);
    endtask : t_reset

    // Every source code against each single fault.
    task automatic t_sources();
        int c, f;
        logic hit;
        for (c = 0; c < 8; c++) begin
            for (f = 0; f < 3; f++) begin
                wr(ADDR_AS_CONTROL, ctl(1'b0, 3'(c), 4'h1), RESP_OKAY);
                fault <= 3'(1 << f);
                go(8);
                hit = c[f];
                chk("flag", 32'(hit), 32'(flag));
                chk("pins", hit ? 32'ha : 32'h5, 32'(pwm_out));
                fault <= 3'h0;
                go(6);
                wr(ADDR_AS_CONTROL, 32'h0, RESP_OKAY);
            end
        end
        go(2);
        chk("flag", 32'h0, 32'(flag));
    endtask : t_sources

    // All sixteen pin-state pairs under a forced shutdown.
    task automatic t_states();
        int s;
        logic [3:0] oe, lv;
        for (s = 0; s < 16; s++) begin
            wr(ADDR_AS_CONTROL, ctl(1'b1, 3'h0, 4'(s)), RESP_OKAY);
            go(2);
            oe = {~s[1], ~s[3], ~s[1], ~s[3]};
            lv = {s[0], s[2], s[0], s[2]};
            chk("flag", 32'h1, 32'(flag));
            chk("oe", 32'(oe), 32'(pwm_oe));
            chk("out", 32'(lv & oe), 32'(pwm_out & oe));
        end
        pwm_in <= 4'h3;
        wr(ADDR_AS_CONTROL, 32'h0, RESP_OKAY);
        go(2);
        chk("oe", 32'hf, 32'(pwm_oe));
        chk("out", 32'h3, 32'(pwm_out));
        pwm_in <= 4'h5;
    endtask : t_states

    // Automatic and manual restart, with the interrupt raised and masked.
    task automatic t_restart();
        wr(ADDR_RESTART, 32'h1, RESP_OKAY);
        wr(ADDR_IRQ_MASK, 32'h3, RESP_OKAY);
        wr(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
        wr(ADDR_AS_CONTROL, ctl(1'b0, 3'h1, 4'h0), RESP_OKAY);
        fault <= 3'h1;
        go(8);
        chk("flag", 32'h1, 32'(flag));
        chk("irq", 32'h1, 32'(irq));
        fault <= 3'h0;
        go(8);
        chk("flag", 32'h0, 32'(flag));
        rd(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
        wr(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
        go(2);
        chk("irq", 32'h0, 32'(irq));
        wr(ADDR_RESTART, 32'h0, RESP_OKAY);
        fault <= 3'h1;
        go(8);
        fault <= 3'h0;
        go(8);
        chk("flag", 32'h1, 32'(flag));
        wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
        go(2);
        chk("irq", 32'h0, 32'(irq));
        wr(ADDR_AS_CONTROL, 32'h0, RESP_OKAY);
        go(2);
        chk("flag", 32'h0, 32'(flag));
    endtask : t_restart

    // Each synchronised comparator in turn waits for the timer tick.
    task automatic t_sync();
        int k;
        for (k = 0; k < 2; k++) begin
            tick_run <= 1'b0;
            sync_en <= 2'(1 << k);
            wr(ADDR_AS_CONTROL, ctl(1'b0, 3'(k + 1), 4'h0), RESP_OKAY);
            fault <= 3'(1 << k);
            go(12);
            chk("flag", 32'h0, 32'(flag));
            tick_run <= 1'b1;
            go(12);
            chk("flag", 32'h1, 32'(flag));
            fault <= 3'h0;
            go(12);
            wr(ADDR_AS_CONTROL, 32'h0, RESP_OKAY);
            go(2);
            chk("flag", 32'h0, 32'(flag));
        end
        sync_en <= 2'h0;
    endtask : t_sync

    // Main sequence: reset for four cycles, then every scenario.
    initial begin
        go(4);
        rst_n <= 1'b1;
        go(2);
        t_reset();
        t_sources();
        t_states();
        t_restart();
        t_sync();
        end_of_test();
    end

    // Cuts a hang short.
    initial begin
        go(40000);
        n_mismatch++;
        end_of_test();
    end
endmodule : pwm_auto_shutdown_tb
